// File: shared/flash_cmd_pkg.sv
// shared constants, types and opcode decoding for the array command decoder
package flash_cmd_pkg;

    // ************************************************************
    // opcodes
    // ************************************************************
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
    localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
    localparam logic [7:0] OP_SHORT_QUAD_IO_READ = 8'he7;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_FOUR_LINE_ENABLE = 8'h35;
    localparam logic [7:0] OP_FOUR_LINE_RESET = 8'hf5;

    // ************************************************************
    // link widths, counts and reset values
    // ************************************************************
    localparam logic [2:0] LINES_1 = 3'h1;
    localparam logic [2:0] LINES_2 = 3'h2;
    localparam logic [2:0] LINES_4 = 3'h4;
    localparam logic [2:0] SUB_LAST_1 = 3'h7; // clocks per byte minus one
    localparam logic [2:0] SUB_LAST_2 = 3'h3;
    localparam logic [2:0] SUB_LAST_4 = 3'h1;
    localparam logic [1:0] ADDR_LAST_BYTE = 2'h2; // three address bytes
    localparam logic [3:0] DUMMY_NONE = 4'h0;
    localparam logic [3:0] DUMMY_EIGHT = 4'h8;
    localparam logic [3:0] DUMMY_SIX = 4'h6;
    localparam logic [3:0] DUMMY_FOUR = 4'h4;
    localparam logic [3:0] OE_OFF = 4'hf; // enables are active low
    localparam logic [3:0] OE_SINGLE = 4'hd;
    localparam logic [3:0] OE_DUAL = 4'hc;
    localparam logic [3:0] OE_QUAD = 4'h0;
    localparam logic CS_IDLE = 1'b1;
    localparam logic QPI_RESET = 1'b0;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        KIND_NONE, KIND_READ, KIND_FAST_READ, KIND_DUAL_OUT_READ,
        KIND_DUAL_IO_READ, KIND_QUAD_OUT_READ, KIND_QUAD_IO_READ,
        KIND_SHORT_QUAD_IO_READ, KIND_PAGE_PROGRAM, KIND_QUAD_PAGE_PROGRAM,
        KIND_SECTOR_ERASE, KIND_HALF_BLOCK_ERASE, KIND_BLOCK_ERASE,
        KIND_CHIP_ERASE, KIND_QPI_ON, KIND_QPI_OFF
    } cmd_kind_e;

    typedef enum logic [2:0] {
        PH_OPC, PH_ADDR, PH_DUMMY, PH_DATA, PH_NOADDR, PH_IGNORE
    } link_phase_e;

    typedef struct packed {
        logic known;
        cmd_kind_e kind;
        logic [2:0] addr_lines;
        logic [3:0] dummy_cyc;
        logic [2:0] data_lines;
        logic has_addr;
        logic is_read;
        logic is_prog;
        logic needs_boundary;
    } cmd_info_s;

    typedef struct packed {
        cmd_kind_e kind;
        logic [23:0] addr;
    } cmd_report_s;

    // ************************************************************
    // decoding
    // ************************************************************
    function automatic cmd_info_s decode_opcode(input logic [7:0] op,
                                                input logic four_line_command_interface);
        cmd_info_s d;
        d = '{known: 1'b1, kind: KIND_NONE, addr_lines: LINES_1,
              dummy_cyc: DUMMY_NONE, data_lines: LINES_1, has_addr: 1'b1,
              is_read: 1'b0, is_prog: 1'b0, needs_boundary: 1'b1};
        case (op)
            OP_READ: begin
                d.kind = KIND_READ;
                d.known = !four_line_command_interface;
            end
            OP_FAST_READ: begin
                d.kind = KIND_FAST_READ;
                d.dummy_cyc = four_line_command_interface ? DUMMY_FOUR : DUMMY_EIGHT;
            end
            OP_DUAL_OUT_READ: begin
                d.kind = KIND_DUAL_OUT_READ;
                d.known = !four_line_command_interface;
                d.dummy_cyc = DUMMY_EIGHT;
                d.data_lines = LINES_2;
            end
            OP_DUAL_IO_READ: begin
                d.kind = KIND_DUAL_IO_READ;
                d.known = !four_line_command_interface;
                d.addr_lines = LINES_2;
                d.dummy_cyc = DUMMY_FOUR;
                d.data_lines = LINES_2;
            end
            OP_QUAD_OUT_READ: begin
                d.kind = KIND_QUAD_OUT_READ;
                d.known = !four_line_command_interface;
                d.dummy_cyc = DUMMY_EIGHT;
                d.data_lines = LINES_4;
            end
            OP_QUAD_IO_READ, OP_SHORT_QUAD_IO_READ: begin
                d.kind = (op == OP_QUAD_IO_READ) ? KIND_QUAD_IO_READ
                                                 : KIND_SHORT_QUAD_IO_READ;
                d.addr_lines = LINES_4;
                d.dummy_cyc = (op == OP_QUAD_IO_READ) ? DUMMY_SIX
                                                      : DUMMY_FOUR;
                d.data_lines = LINES_4;
            end
            OP_PAGE_PROGRAM: d.kind = KIND_PAGE_PROGRAM;
            OP_QUAD_PAGE_PROGRAM: begin
                d.kind = KIND_QUAD_PAGE_PROGRAM;
                d.known = !four_line_command_interface;
                d.data_lines = LINES_4;
            end
            OP_SECTOR_ERASE: d.kind = KIND_SECTOR_ERASE;
            OP_HALF_BLOCK_ERASE: d.kind = KIND_HALF_BLOCK_ERASE;
            OP_BLOCK_ERASE: d.kind = KIND_BLOCK_ERASE;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: d.kind = KIND_CHIP_ERASE;
            OP_FOUR_LINE_ENABLE: begin
                d.kind = KIND_QPI_ON;
                d.known = !four_line_command_interface;
            end
            OP_FOUR_LINE_RESET: begin
                d.kind = KIND_QPI_OFF;
                d.known = four_line_command_interface;
            end
            default: d.known = 1'b0;
        endcase
        if (d.kind == KIND_CHIP_ERASE || d.kind == KIND_QPI_ON ||
            d.kind == KIND_QPI_OFF) begin
            d.has_addr = 1'b0;
        end
        d.is_read = d.kind inside {KIND_READ, KIND_FAST_READ,
            KIND_DUAL_OUT_READ, KIND_DUAL_IO_READ, KIND_QUAD_OUT_READ,
            KIND_QUAD_IO_READ, KIND_SHORT_QUAD_IO_READ};
        d.is_prog = d.kind inside {KIND_PAGE_PROGRAM, KIND_QUAD_PAGE_PROGRAM};
        d.needs_boundary = !d.is_read;
        if (four_line_command_interface) begin
            d.addr_lines = LINES_4;
            d.data_lines = LINES_4;
        end
        return d;
    endfunction

    // last clock index inside one byte for a given number of lines
    function automatic logic [2:0] sub_last(input logic [2:0] lines);
        case (lines)
            LINES_2: sub_last = SUB_LAST_2;
            LINES_4: sub_last = SUB_LAST_4;
            default: sub_last = SUB_LAST_1;
        endcase
    endfunction

endpackage

// File: core/flash_array_command_decoder.sv
// serial link front end that decodes array read, program and erase commands
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - 03h: three single-line address bytes, no dummy, then data until deselect
// - 0Bh: three address bytes, eight dummy clocks on one line, then data
// - 0Bh in four-line command mode uses four dummy clocks
// - 3Bh: single-line address, eight dummy clocks, data on two lines
// - BBh: address four clocks per byte on two lines, four dummy clocks
// - two-line transfers put the upper bit of each pair on line one
// - two-line address clock carries two bits, four clocks per byte
// - 6Bh: single-line address, eight dummy clocks, data on four lines
// - EBh: address two clocks per byte on four lines, six dummy clocks
// - E7h: address two clocks per byte on four lines, four dummy clocks
// - 02h: three address bytes then program data for the page
// - 38h: single-line address then program data on four lines
// - 20h: three address bytes, erases the containing sector
// - 52h: three address bytes, erases the containing 32 KB block
// - D8h: three address bytes, erases the containing 64 KB block
// - 60h or C7h: single byte, erases the whole array
// - each field lasts the stated number of serial clocks
// - inputs taken on rising clock, outputs shifted on falling clock
// - program or erase ends on a byte boundary or is rejected
// - unknown opcode: outputs released, link ignored until next select
// - 35h enters four-line command mode
module flash_array_command_decoder (
    input wire logic clk, // system clock, 100 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic sclk, // serial clock from the host
    input wire logic cs_n, // chip select from the host, active low
    input wire logic [3:0] io_i, // data lines seen at the pins
    output logic [3:0] io_o, // data lines driven by the device
    output logic [3:0] io_oe_n, // per-line output enable, active low
    output logic [23:0] array_rd_addr, // read address, sclk domain
    input wire logic [7:0] array_rd_data, // read byte, sclk domain
    output logic [7:0] prog_byte, // received program byte
    output logic [23:0] prog_addr, // address of prog_byte
    output logic prog_strobe, // prog_byte valid, sclk pulse
    output flash_cmd_pkg::cmd_report_s cmd_report, // accepted command
    output logic cmd_valid, // cmd_report valid, clk pulse
    output logic cmd_rejected, // program or erase dropped, clk pulse
    output logic qpi_mode // four-line command mode is on
);
    import flash_cmd_pkg::*;

    // ************************************************************
    // link side, sclk domain
    // ************************************************************
    logic active_reg;
    link_phase_e phase_reg;
    logic [2:0] sub_reg;
    logic [1:0] byte_cnt_reg;
    logic [3:0] dum_cnt_reg;
    logic [7:0] shin_reg;
    logic [7:0] opcode_reg;
    logic [23:0] addr_reg;
    cmd_info_s info_reg;
    logic link_tag_reg;
    logic [7:0] prog_byte_reg;
    logic [23:0] prog_addr_reg;
    logic prog_strobe_reg;
    logic [7:0] tx_reg;
    logic [3:0] io_o_reg;
    logic [3:0] io_oe_n_reg;
    logic qpi_mode_reg;
    logic frame_tag_reg;

    link_phase_e phase_cur;
    logic [2:0] sub_cur;
    logic [2:0] lines_now;
    logic [7:0] shin_next;
    logic byte_end;
    cmd_info_s info_now;
    logic [7:0] tx_byte;

    // the first edge of a frame finds stale state, so force the opcode phase
    always_comb begin
        phase_cur = active_reg ? phase_reg : PH_OPC;
        sub_cur = active_reg ? sub_reg : 3'h0;
        case (phase_cur)
            PH_OPC: lines_now = qpi_mode_reg ? LINES_4 : LINES_1;
            PH_ADDR: lines_now = info_reg.addr_lines;
            PH_DATA: lines_now = info_reg.data_lines;
            default: lines_now = qpi_mode_reg ? LINES_4 : LINES_1;
        endcase
        case (lines_now) // upper bit of a pair arrives on line one
            LINES_2: shin_next = {shin_reg[5:0], io_i[1:0]};
            LINES_4: shin_next = {shin_reg[3:0], io_i[3:0]};
            default: shin_next = {shin_reg[6:0], io_i[0]};
        endcase
        byte_end = (sub_cur == sub_last(lines_now));
        info_now = decode_opcode(shin_next, qpi_mode_reg);
        tx_byte = (sub_reg == 3'h0) ? array_rd_data : tx_reg;
    end

    // frame activity, cleared the moment select rises
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= 1'b1;
        end
    end

    // dummy clocks hold the sub-byte count at zero so data starts on a byte;
    // left standing after deselect for the byte boundary judgement
    always_ff @(posedge sclk) begin
        shin_reg <= shin_next;
        sub_reg <= (byte_end || phase_cur == PH_DUMMY) ? 3'h0 : sub_cur + 3'h1;
        if (!active_reg) begin
            link_tag_reg <= frame_tag_reg; // marks the frame as seen
        end
    end

    // phase sequencing through opcode, address, dummy and data
    always_ff @(posedge sclk) begin
        phase_reg <= phase_cur;
        case (phase_cur)
            PH_OPC: if (byte_end) begin
                opcode_reg <= shin_next;
                info_reg <= info_now;
                byte_cnt_reg <= 2'h0;
                dum_cnt_reg <= DUMMY_NONE;
                if (!info_now.known) begin
                    phase_reg <= PH_IGNORE;
                end else if (info_now.has_addr) begin
                    phase_reg <= PH_ADDR;
                end else begin
                    phase_reg <= PH_NOADDR;
                end
            end
            PH_ADDR: if (byte_end) begin
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
                if (byte_cnt_reg == ADDR_LAST_BYTE) begin
                    phase_reg <= (info_reg.dummy_cyc == DUMMY_NONE)
                                 ? PH_DATA : PH_DUMMY;
                end
            end
            PH_DUMMY: begin
                dum_cnt_reg <= dum_cnt_reg + 4'h1;
                if (dum_cnt_reg == info_reg.dummy_cyc - 4'h1) begin
                    phase_reg <= PH_DATA;
                end
            end
            default: phase_reg <= phase_cur; // data streams until deselect
        endcase
    end

    // address assembly, then a walking address through the data phase
    always_ff @(posedge sclk) begin
        if (phase_cur == PH_ADDR && byte_end) begin
            addr_reg <= {addr_reg[15:0], shin_next}; // msb first
        end else if (phase_cur == PH_DATA && byte_end) begin
            addr_reg <= addr_reg + 24'h1;
        end
    end

    // program data handed out byte by byte
    always_ff @(posedge sclk) begin
        if (phase_cur == PH_DATA && byte_end && info_reg.is_prog) begin
            prog_byte_reg <= shin_next;
            prog_addr_reg <= addr_reg;
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            prog_strobe_reg <= 1'b0;
        end else begin
            prog_strobe_reg <= phase_cur == PH_DATA && byte_end &&
                               info_reg.is_prog;
        end
    end

    // read data leaves on the falling edge; lines stay released otherwise,
    // which also covers an unknown opcode until the next select
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_reg <= 8'h00;
            io_o_reg <= 4'h0;
            io_oe_n_reg <= OE_OFF;
        end else if (active_reg && phase_reg == PH_DATA && info_reg.is_read)
        begin
            case (info_reg.data_lines)
                LINES_2: begin // upper bit on line one
                    io_o_reg <= {2'b00, tx_byte[7:6]};
                    io_oe_n_reg <= OE_DUAL;
                    tx_reg <= {tx_byte[5:0], 2'b00};
                end
                LINES_4: begin
                    io_o_reg <= tx_byte[7:4];
                    io_oe_n_reg <= OE_QUAD;
                    tx_reg <= {tx_byte[3:0], 4'h0};
                end
                default: begin // single line leaves on line one
                    io_o_reg <= {2'b00, tx_byte[7], 1'b0};
                    io_oe_n_reg <= OE_SINGLE;
                    tx_reg <= {tx_byte[6:0], 1'b0};
                end
            endcase
        end else begin
            io_o_reg <= 4'h0;
            io_oe_n_reg <= OE_OFF;
        end
    end

    // ************************************************************
    // system side, clk domain
    // ************************************************************
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic cmd_valid_reg;
    logic cmd_rejected_reg;
    cmd_report_s cmd_report_reg;
    logic cs_rise;
    logic frame_seen;
    logic complete;
    logic boundary;
    logic accept;

    // the frame summary is only read three clk edges after select rose, when
    // sclk has stopped; the host must hold select high for at least 40 ns
    always_comb begin
        cs_rise = cs_sync_reg && !cs_prev_reg;
        frame_seen = (link_tag_reg == frame_tag_reg);
        complete = (phase_reg == PH_DATA) || (phase_reg == PH_NOADDR);
        boundary = (sub_reg == 3'h0);
        accept = cs_rise && frame_seen && info_reg.known && complete &&
                 (boundary || !info_reg.needs_boundary);
    end

    // select is a pin: two flops before anything looks at it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_meta_reg <= CS_IDLE;
            cs_sync_reg <= CS_IDLE;
            cs_prev_reg <= CS_IDLE;
        end else begin
            cs_meta_reg <= cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    // frame tag flips after each frame so of empty frames in a row the first, third and so on are not re-judged, but the second, fourth and so on are
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frame_tag_reg <= 1'b0;
        end else if (cs_rise) begin
            frame_tag_reg <= !frame_tag_reg;
        end
    end

    // command acceptance or rejection at the end of a frame
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_valid_reg <= 1'b0;
            cmd_rejected_reg <= 1'b0;
            cmd_report_reg <= '{kind: KIND_NONE, addr: 24'h000000};
        end else begin
            cmd_valid_reg <= accept;
            cmd_rejected_reg <= cs_rise && frame_seen && info_reg.known &&
                                info_reg.needs_boundary &&
                                !(complete && boundary);
            if (accept) begin
                cmd_report_reg.kind <= info_reg.kind;
                cmd_report_reg.addr <= info_reg.has_addr ? addr_reg
                                                         : 24'h000000;
            end
        end
    end

    // four-line command mode, changed only between frames
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            qpi_mode_reg <= QPI_RESET;
        end else if (accept && info_reg.kind == KIND_QPI_ON) begin
            qpi_mode_reg <= 1'b1;
        end else if (accept && info_reg.kind == KIND_QPI_OFF) begin
            qpi_mode_reg <= 1'b0;
        end
    end

    assign io_o = io_o_reg;
    assign io_oe_n = io_oe_n_reg;
    assign array_rd_addr = addr_reg;
    assign prog_byte = prog_byte_reg;
    assign prog_addr = prog_addr_reg;
    assign prog_strobe = prog_strobe_reg;
    assign cmd_report = cmd_report_reg;
    assign cmd_valid = cmd_valid_reg;
    assign cmd_rejected = cmd_rejected_reg;
    assign qpi_mode = qpi_mode_reg;

    // ************************************************************
    // checks
    // ************************************************************
    sequence addr_start(logic [7:0] op);
        active_reg && phase_reg == PH_ADDR && byte_cnt_reg == 2'h0 &&
        sub_reg == 3'h0 && opcode_reg == op;
    endsequence

    read_no_dummy_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_READ) |-> ##24 phase_reg == PH_DATA)
        else $error("plain read address phase length wrong");
    fast_spi_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_FAST_READ) and !qpi_mode_reg
        |-> ##24 phase_reg == PH_DUMMY ##8 phase_reg == PH_DATA)
        else $error("fast read single-line timing wrong");
    fast_qpi_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_FAST_READ) and qpi_mode_reg
        |-> ##6 phase_reg == PH_DUMMY ##4 phase_reg == PH_DATA)
        else $error("fast read four-line timing wrong");
    dual_out_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_DUAL_OUT_READ)
        |-> ##32 phase_reg == PH_DATA && info_reg.data_lines == LINES_2)
        else $error("dual output read timing wrong");
    dual_io_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_DUAL_IO_READ)
        |-> ##12 phase_reg == PH_DUMMY ##4 phase_reg == PH_DATA)
        else $error("dual io read timing wrong");
    quad_out_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_QUAD_OUT_READ)
        |-> ##32 phase_reg == PH_DATA && info_reg.data_lines == LINES_4)
        else $error("quad output read timing wrong");
    quad_io_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_QUAD_IO_READ)
        |-> ##6 phase_reg == PH_DUMMY ##6 phase_reg == PH_DATA)
        else $error("quad io read timing wrong");
    short_quad_a: assert property (@(posedge sclk) disable iff (cs_n)
        addr_start(OP_SHORT_QUAD_IO_READ) |-> ##10 phase_reg == PH_DATA)
        else $error("short dummy quad read timing wrong");
    ignore_hiz_a: assert property (@(posedge sclk) disable iff (cs_n)
        active_reg && phase_reg == PH_IGNORE |-> io_oe_n == OE_OFF)
        else $error("lines driven after unknown opcode");
    reject_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        cs_rise && frame_seen && info_reg.known && info_reg.needs_boundary
        && !boundary |=> cmd_rejected && !cmd_valid)
        else $error("unaligned program or erase not rejected");
    qpi_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
        accept && info_reg.kind == KIND_QPI_ON |=> qpi_mode ##1 qpi_mode)
        else $error("four-line mode not entered");
endmodule

`default_nettype wire

// File: verification/flash_host_model.sv
// host serial controller model that drives whole frames onto the link
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
    output logic sclk, // serial clock, still between frames
    output logic cs_n, // chip select, active low
    output logic [3:0] h_io, // host drive on each line
    input wire logic [3:0] io_i // resolved pin levels
);
    // ********************
    // frame driver
    // ********************
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        h_io = 4'h5;
    end

    // idle lines toggle every bit so a stale level never looks valid; w is
    // the number of lines that carry the header and the read data
    task automatic frame(input logic [39:0] hdr, input int w, input int nb,
                         input int ext, output logic [7:0] rx);
        logic [39:0] sh;
        sh = hdr;
        rx = 8'h00;
        #45 cs_n = 1'b0; // deselect gap above 40 ns
        for (int i = 0; i < nb + ext; i++) begin
            if (w == 4) h_io = sh[39:36]; // four-line header
            else h_io = {~h_io[3:1], sh[39]}; // msb first
            sh = sh << w;
            #7 sclk = 1'b1; // device latches here
            if (i >= nb && w == 4) rx = {rx[3:0], io_i};
            else if (i >= nb) rx = {rx[6:0], io_i[1]};
            #8 sclk = 1'b0;
        end
        #7 cs_n = 1'b1; // ends on a whole clock count
    endtask
endmodule
`default_nettype wire

// File: verification/flash_array_command_decoder_tb_top.sv
// self-checking bench for the array command decoder
`timescale 1ns/1ns
`default_nettype none
module flash_array_command_decoder_tb_top;
    import flash_cmd_pkg::*;
    logic clk, sys_rst, sclk, cs_n, prog_strobe, got_v, got_r;
    logic cmd_valid, cmd_rejected, qpi_mode;
    logic [3:0] h_io, io_i, io_o, io_oe_n;
    logic [23:0] array_rd_addr, prog_addr;
    logic [7:0] prog_byte, rx;
    cmd_report_s cmd_report;
    int err_total = 0;
    int num_checks = 0;
    int strobes = 0;

    // counts program byte strobes as they leave the link side
    always @(posedge prog_strobe) strobes++;

    // ********************
    // wiring
    // ********************
    // each pin follows whichever side enables it
    assign io_i = (io_oe_n & h_io) | (~io_oe_n & io_o);
    flash_host_model u_host (.sclk(sclk), .cs_n(cs_n), .h_io(h_io),
        .io_i(io_i));
    flash_array_command_decoder u_dut (.clk(clk), .sys_rst(sys_rst),
        .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o),
        .io_oe_n(io_oe_n), .array_rd_addr(array_rd_addr),
        .array_rd_data(8'ha5), .prog_byte(prog_byte),
        .prog_addr(prog_addr), .prog_strobe(prog_strobe),
        .cmd_report(cmd_report), .cmd_valid(cmd_valid),
        .cmd_rejected(cmd_rejected), .qpi_mode(qpi_mode));
    // system clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ********************
    // checking helpers
    // ********************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // fixed window covers the 3 to 4 clk result delay
    task automatic wait_res();
        got_v = 1'b0;
        got_r = 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (cmd_valid === 1'b1) got_v = 1'b1;
            if (cmd_rejected === 1'b1) got_r = 1'b1;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic t_erase();
        u_host.frame({OP_BLOCK_ERASE, 24'h123456, 8'h00}, 1, 32, 0, rx);
        wait_res();
        chk({got_v, got_r}, 2'b10);
        chk(cmd_report, {KIND_BLOCK_ERASE, 24'h123456});
        u_host.frame({OP_SECTOR_ERASE, 32'h0}, 1, 33, 0, rx);
        wait_res();
        chk({got_v, got_r}, 2'b01);
    endtask
    task automatic t_chip();
        logic [7:0] ops[2] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
        foreach (ops[k]) begin
            u_host.frame({ops[k], 32'h0}, 1, 8, 0, rx);
            wait_res();
            chk({got_v, cmd_report}, {1'b1, KIND_CHIP_ERASE, 24'h0});
        end
    endtask
    // plain read has no dummy, fast read eight dummy clocks
    task automatic t_reads();
        logic [7:0] ops[2] = '{OP_READ, OP_FAST_READ};
        cmd_kind_e kinds[2] = '{KIND_READ, KIND_FAST_READ};
        int dum[2] = '{0, 8};
        foreach (ops[k]) begin
            u_host.frame({ops[k], 24'h000100, 8'h00}, 1, 32 + dum[k], 8, rx);
            chk(rx, 8'ha5);
            chk(array_rd_addr, 24'h000101);
            wait_res();
            // the report carries the address as it stood at deselect
            chk(cmd_report, {kinds[k], 24'h000101});
        end
    endtask
    task automatic t_unknown_then_qpi();
        u_host.frame({8'h9f, 32'h0}, 1, 32, 8, rx);
        wait_res();
        chk({got_v, got_r}, 2'b00);
        u_host.frame({OP_FOUR_LINE_ENABLE, 32'h0}, 1, 8, 0, rx);
        wait_res();
        chk({qpi_mode, cmd_report}, {1'b1, KIND_QPI_ON, 24'h0});
    endtask
    // one program byte: one strobe, the byte and the address it belongs to
    task automatic t_prog();
        int s0;
        s0 = strobes;
        u_host.frame({OP_PAGE_PROGRAM, 24'h000300, 8'h3c}, 1, 40, 0, rx);
        chk(strobes - s0, 1);
        chk({prog_byte, prog_addr}, {8'h3c, 24'h000300});
        wait_res();
        chk(got_v, 1);
        chk(cmd_report, {KIND_PAGE_PROGRAM, 24'h000301});
    endtask
    // four-line mode: opcode two clocks, address six, then the dummy count
    task automatic t_qpi_reads();
        logic [7:0] ops[3] = '{OP_QUAD_IO_READ, OP_FAST_READ,
                               OP_SHORT_QUAD_IO_READ};
        cmd_kind_e kinds[3] = '{KIND_QUAD_IO_READ, KIND_FAST_READ,
                                KIND_SHORT_QUAD_IO_READ};
        int dum[3] = '{6, 4, 4};
        foreach (ops[k]) begin
            u_host.frame({ops[k], 24'h000200, 8'h00}, 4, 8 + dum[k], 2, rx);
            chk(rx, 8'ha5);
            wait_res();
            chk(cmd_report, {kinds[k], 24'h000201});
        end
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_erase();
        t_chip();
        t_reads();
        t_prog();
        t_unknown_then_qpi();
        t_qpi_reads();
        print_verdict();
    end
    // hang guard
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
